// *** hw/cdr_host.sv ***
// Host end: root complex with shared memory and an AXI4-Lite controller.
// Assumes software programs the descriptor table and header over AXI4-Lite.
`timescale 1ns/100ps
module cdr_host
  import cdr_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              nrst,
  // Link to the device.
  cdr_link_if.host               link,
  // AXI4-Lite write channels.
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels.
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Interrupt.
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------
  function automatic cdr_region_e region(input logic [AXI_AW-1:0] a);
    if (a >= HC_MEM_BASE) begin
      region = HR_MEM;
    end else if (a[15:8] == HC_HDR_BASE[15:8]) begin
      region = HR_HDR;
    end else if (a == HC_IRQ_STATUS || a == HC_IRQ_MASK || a == HC_MSI_COUNT) begin
      region = HR_CTRL;
    end else begin
      region = HR_NONE;
    end
  endfunction : region

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  cdr_host_st_e      st_r, st_nxt;
  logic              aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [AXI_AW-1:0] addr_r, addr_nxt;
  logic [31:0]       wd_r, wd_nxt;
  logic [3:0]        ws_r, ws_nxt;
  logic [1:0]        resp_r, resp_nxt;
  logic [31:0]       rd_r, rd_nxt;
  logic [31:0]       stat_r, stat_nxt, mask_r, mask_nxt, msicnt_r, msicnt_nxt;
  logic [3:0][7:0]   hmem [2**HM_AW];
  logic              dev_rd;
  logic              axi_we;
  logic [HM_AW-1:0]  axi_idx;
  logic [31:0]       rsp_r;
  logic              rsp_v_r;
  logic              msi_take;

  assign axi_idx  = addr_r[HM_AW+1:2];
  assign dev_rd   = link.mem_valid && !link.mem_write;
  assign msi_take = link.msi_valid && link.msi_ready;

  assign awready = (st_r == HS_IDLE) && !aw_got_r;
  assign wready  = (st_r == HS_IDLE) && !w_got_r;
  assign arready = (st_r == HS_IDLE) && !aw_got_r && !w_got_r && !awvalid && !wvalid;
  assign bvalid  = (st_r == HS_BRESP);
  assign rvalid  = (st_r == HS_RRESP);
  assign bresp   = resp_r;
  assign rresp   = resp_r;
  assign rdata   = rd_r;
  assign irq     = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // Link drive; the device always gets the memory port first.
  // ----------------------------------------------------------------
  assign link.cfg_valid = (st_r == HS_WCFG) || (st_r == HS_RCFG);
  assign link.cfg_write = (st_r == HS_WCFG);
  assign link.cfg_addr  = addr_r[7:0];
  assign link.cfg_wdata = wd_r;
  assign link.mem_ready = 1'b1;
  assign link.msi_ready = 1'b1;
  assign link.rsp_valid = rsp_v_r;
  assign link.rsp_data  = rsp_r;

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    aw_got_nxt = aw_got_r || (awvalid && awready);
    w_got_nxt  = w_got_r || (wvalid && wready);
    addr_nxt   = (awvalid && awready) ? awaddr : addr_r;
    wd_nxt     = (wvalid && wready) ? wdata : wd_r;
    ws_nxt     = (wvalid && wready) ? wstrb : ws_r;
    resp_nxt   = resp_r;
    rd_nxt     = rd_r;
    mask_nxt   = mask_r;
    stat_nxt   = stat_r;
    msicnt_nxt = msicnt_r + {31'h0, msi_take};
    axi_we     = 1'b0;
    case (st_r)
      HS_IDLE: begin
        if (aw_got_r && w_got_r) begin
          aw_got_nxt = 1'b0;
          w_got_nxt  = 1'b0;
          resp_nxt   = RESP_OKAY;
          st_nxt     = HS_BRESP;
          case (region(addr_r))
            HR_HDR: st_nxt = HS_WCFG;
            HR_MEM: st_nxt = HS_WMEM;
            HR_CTRL: begin
              if (addr_r == HC_IRQ_STATUS) begin
                stat_nxt = stat_r & ~wd_r;
              end else if (addr_r == HC_IRQ_MASK) begin
                mask_nxt = wd_r;
              end
            end
            default: resp_nxt = RESP_DECERR;
          endcase
        end else if (arvalid && arready) begin
          addr_nxt = araddr;
          resp_nxt = RESP_OKAY;
          rd_nxt   = 32'h0;
          st_nxt   = HS_RRESP;
          case (region(araddr))
            HR_HDR: st_nxt = HS_RCFG;
            HR_MEM: st_nxt = HS_RMEM;
            HR_CTRL: begin
              rd_nxt = (araddr == HC_IRQ_STATUS) ? stat_r :
                       (araddr == HC_IRQ_MASK)   ? mask_r : msicnt_r;
            end
            default: resp_nxt = RESP_DECERR;
          endcase
        end
      end
      HS_WCFG: begin
        if (link.cfg_ack) begin
          st_nxt = HS_BRESP;
        end
      end
      HS_WMEM: begin
        if (!link.mem_valid) begin
          axi_we = 1'b1;
          st_nxt = HS_BRESP;
        end
      end
      HS_BRESP: begin
        if (bready) begin
          st_nxt = HS_IDLE;
        end
      end
      HS_RCFG: begin
        if (link.cfg_ack) begin
          rd_nxt = link.cfg_rdata;
          st_nxt = HS_RRESP;
        end
      end
      HS_RMEM: begin
        if (!link.mem_valid) begin
          rd_nxt = hmem[axi_idx];
          st_nxt = HS_RRESP;
        end
      end
      HS_RRESP: begin
        if (rready) begin
          st_nxt = HS_IDLE;
        end
      end
      default: st_nxt = HS_IDLE;
    endcase
    if (msi_take) begin
      stat_nxt[IRQ_DONE_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r     <= HS_IDLE;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      addr_r   <= '0;
      wd_r     <= 32'h0;
      ws_r     <= 4'h0;
      resp_r   <= RESP_OKAY;
      rd_r     <= 32'h0;
      stat_r   <= 32'h0;
      mask_r   <= 32'h0;
      msicnt_r <= 32'h0;
      rsp_v_r  <= 1'b0;
      rsp_r    <= 32'h0;
    end else begin
      st_r     <= st_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      addr_r   <= addr_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      resp_r   <= resp_nxt;
      rd_r     <= rd_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      msicnt_r <= msicnt_nxt;
      rsp_v_r  <= dev_rd;
      rsp_r    <= dev_rd ? hmem[link.mem_addr[HM_AW+1:2]] : rsp_r;
    end
  end

  // ----------------------------------------------------------------
  // Shared memory.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (link.mem_valid && link.mem_write) begin
      hmem[link.mem_addr[HM_AW+1:2]] <= link.mem_wdata;
    end else if (axi_we) begin
      for (int b = 0; b < 4; b++) begin
        if (ws_r[b]) begin
          hmem[axi_idx][b] <= wd_r[8*b +: 8];
        end
      end
    end
  end

endmodule : cdr_host

// *** shared/cdr_pkg.sv ***
// Constants and types shared by both ends of the chained DMA read link.
// Assumes a single 10 MHz clock and an active-low asynchronous reset.
package cdr_pkg;

  // ----------------------------------------------------------------
  // Header registers of the read engine (byte offsets on the link).
  // ----------------------------------------------------------------
  localparam logic [7:0]  HDR_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  HDR_UPPER_OFS  = 8'h14;
  localparam logic [7:0]  HDR_LOWER_OFS  = 8'h18;
  localparam logic [7:0]  HDR_LAST_OFS   = 8'h1c;
  localparam logic [31:0] HDR_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Descriptor table layout in host memory.
  // ----------------------------------------------------------------
  localparam logic [63:0] TBL_STATUS_OFS = 64'h0000_0000_0000_000c;
  localparam logic [63:0] TBL_FIRST_OFS  = 64'h0000_0000_0000_0010;
  localparam int          DESC_SHIFT     = 4;
  localparam int          DESC_WORDS     = 4;
  localparam int          LEN_W          = 16;
  localparam int          ENDPOINT_LAST_FLAG_REQ_BIT = 16;
  localparam int          ENDPOINT_LAST_FLAG_BIT     = 16;

  // ----------------------------------------------------------------
  // Memory sizes.
  // ----------------------------------------------------------------
  localparam int          EP_AW          = 12;
  localparam int          HM_AW          = 12;

  // ----------------------------------------------------------------
  // Host controller registers on AXI4-Lite.
  // ----------------------------------------------------------------
  localparam int          AXI_AW         = 16;
  localparam logic [15:0] HC_IRQ_STATUS  = 16'h0000;
  localparam logic [15:0] HC_IRQ_MASK    = 16'h0004;
  localparam logic [15:0] HC_MSI_COUNT   = 16'h0008;
  localparam logic [15:0] HC_HDR_BASE    = 16'h0100;
  localparam logic [15:0] HC_MEM_BASE    = 16'h4000;
  localparam int          IRQ_DONE_BIT   = 0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  typedef enum logic [2:0] {
    DS_IDLE, DS_DESC_REQ, DS_DESC_WAIT, DS_DATA_REQ, DS_DATA_WAIT, DS_STAT_WR, DS_MSI
  } cdr_dev_st_e;

  typedef enum logic [2:0] {
    HS_IDLE, HS_WCFG, HS_WMEM, HS_BRESP, HS_RCFG, HS_RMEM, HS_RRESP
  } cdr_host_st_e;

  typedef enum logic [1:0] {
    HR_NONE, HR_CTRL, HR_HDR, HR_MEM
  } cdr_region_e;

endpackage : cdr_pkg

// *** shared/cdr_link_if.sv ***
// Link between the chained DMA read engine and the host with its memory.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/100ps
interface cdr_link_if;
  // Header register access, host to device.
  logic        cfg_valid;
  logic        cfg_write;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata;
  logic        cfg_ack;
  logic [31:0] cfg_rdata;
  // Host memory requests, device to host.
  logic        mem_valid;
  logic        mem_write;
  logic [63:0] mem_addr;
  logic [31:0] mem_wdata;
  logic        mem_ready;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  // Completion message.
  logic        msi_valid;
  logic        msi_ready;

  modport dev (
    input  cfg_valid, cfg_write, cfg_addr, cfg_wdata, mem_ready, rsp_valid, rsp_data,
           msi_ready,
    output cfg_ack, cfg_rdata, mem_valid, mem_write, mem_addr, mem_wdata, msi_valid
  );
  modport host (
    output cfg_valid, cfg_write, cfg_addr, cfg_wdata, mem_ready, rsp_valid, rsp_data,
           msi_ready,
    input  cfg_ack, cfg_rdata, mem_valid, mem_write, mem_addr, mem_wdata, msi_valid
  );
endinterface : cdr_link_if

// *** hw/cdr_dev.sv ***
// Chained DMA read engine: endpoint end of the link.
// Assumes the host answers each read request with one rsp_valid pulse.
`timescale 1ns/100ps

// Functional notes
// - Data moves only from host to endpoint memory.
// - Header dwords at 0x0, 0x14, 0x18, 0x1c.
// - Chain starts when last-index dword is written.
// - Descriptor: length/ctrl, endpoint addr, upper, lower.
// - Descriptors 16 bytes apart, first at base+16.
// - Software places table and writes its base.
// - Completed count written to table base plus 12.
// - Endpoint-last flag set on first and last descriptor; here only when that descriptor's control bit 16 requests it.
// - Message interrupt after the last descriptor completes.
module cdr_dev
  import cdr_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             nrst,
  // Link to the host.
  cdr_link_if.dev               link,
  // Endpoint memory read port and state.
  input  wire logic [EP_AW-1:0] ep_rd_addr,
  output logic      [31:0]      ep_rd_data,
  output logic                  busy
);

  // ----------------------------------------------------------------
  // Header register decode.
  // ----------------------------------------------------------------
  function automatic logic [1:0] hdr_sel(input logic [7:0] a);
    case (a)
      HDR_UPPER_OFS: hdr_sel = 2'h1;
      HDR_LOWER_OFS: hdr_sel = 2'h2;
      HDR_LAST_OFS:  hdr_sel = 2'h3;
      default:       hdr_sel = 2'h0;
    endcase
  endfunction : hdr_sel

  function automatic logic hdr_hit(input logic [7:0] a);
    hdr_hit = (a == HDR_CTRL_OFS) || (a == HDR_UPPER_OFS) ||
              (a == HDR_LOWER_OFS) || (a == HDR_LAST_OFS);
  endfunction : hdr_hit

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [31:0]      hdr_r   [4];
  logic [31:0]      hdr_nxt [4];
  logic             cfg_ack_r, cfg_ack_nxt;
  logic [31:0]      cfg_rdata_r, cfg_rdata_nxt;
  cdr_dev_st_e      st_r, st_nxt;
  logic [LEN_W-1:0] didx_r, didx_nxt;
  logic [1:0]       wsel_r, wsel_nxt;
  logic [31:0]      desc_r  [DESC_WORDS];
  logic [31:0]      desc_nxt[DESC_WORDS];
  logic [LEN_W-1:0] dcnt_r, dcnt_nxt;
  logic             ep_we;
  logic [EP_AW-1:0] ep_waddr;
  logic [31:0]      ep_mem [2**EP_AW];
  logic [63:0]      tbl_base;
  logic [LEN_W-1:0] done_cnt;
  logic             cfg_take;

  assign tbl_base = {hdr_r[1], hdr_r[2]};
  assign done_cnt = didx_r + 16'h0001;
  assign cfg_take = link.cfg_valid && !cfg_ack_r;

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    hdr_nxt       = hdr_r;
    desc_nxt      = desc_r;
    cfg_ack_nxt   = cfg_take;
    cfg_rdata_nxt = cfg_rdata_r;
    st_nxt        = st_r;
    didx_nxt      = didx_r;
    wsel_nxt      = wsel_r;
    dcnt_nxt      = dcnt_r;
    ep_we         = 1'b0;
    ep_waddr      = desc_r[1][EP_AW-1:0] + dcnt_r[EP_AW-1:0];
    if (cfg_take) begin
      if (link.cfg_write && hdr_hit(link.cfg_addr)) begin
        hdr_nxt[hdr_sel(link.cfg_addr)] = link.cfg_wdata;
      end
      cfg_rdata_nxt = hdr_hit(link.cfg_addr) ? hdr_r[hdr_sel(link.cfg_addr)] : 32'h0;
    end
    case (st_r)
      DS_IDLE: begin
        if (cfg_take && link.cfg_write && link.cfg_addr == HDR_LAST_OFS) begin
          st_nxt   = DS_DESC_REQ;
          didx_nxt = '0;
          wsel_nxt = 2'h0;
        end
      end
      DS_DESC_REQ: begin
        if (link.mem_ready) begin
          st_nxt = DS_DESC_WAIT;
        end
      end
      DS_DESC_WAIT: begin
        if (link.rsp_valid) begin
          desc_nxt[wsel_r] = link.rsp_data;
          dcnt_nxt         = '0;
          if (wsel_r == 2'h3) begin
            st_nxt = (desc_r[0][LEN_W-1:0] == '0) ? DS_STAT_WR : DS_DATA_REQ;
          end else begin
            wsel_nxt = wsel_r + 2'h1;
            st_nxt   = DS_DESC_REQ;
          end
        end
      end
      DS_DATA_REQ: begin
        if (link.mem_ready) begin
          st_nxt = DS_DATA_WAIT;
        end
      end
      DS_DATA_WAIT: begin
        if (link.rsp_valid) begin
          ep_we    = 1'b1;
          dcnt_nxt = dcnt_r + 16'h0001;
          st_nxt   = (dcnt_nxt == desc_r[0][LEN_W-1:0]) ? DS_STAT_WR : DS_DATA_REQ;
        end
      end
      DS_STAT_WR: begin
        if (link.mem_ready) begin
          if (didx_r == hdr_r[3][LEN_W-1:0]) begin
            st_nxt = DS_MSI;
          end else begin
            didx_nxt = done_cnt;
            wsel_nxt = 2'h0;
            st_nxt   = DS_DESC_REQ;
          end
        end
      end
      DS_MSI: begin
        if (link.msi_ready) begin
          st_nxt = DS_IDLE;
        end
      end
      default: st_nxt = DS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Host memory request payload.
  // ----------------------------------------------------------------
  always_comb begin
    link.mem_valid = (st_r == DS_DESC_REQ) || (st_r == DS_DATA_REQ) || (st_r == DS_STAT_WR);
    link.mem_write = (st_r == DS_STAT_WR);
    link.mem_wdata = 32'h0;
    case (st_r)
      DS_DESC_REQ: begin
        link.mem_addr = tbl_base + TBL_FIRST_OFS
                      + ({48'h0, didx_r} << DESC_SHIFT) + {60'h0, wsel_r, 2'b00};
      end
      DS_DATA_REQ: begin
        link.mem_addr = {desc_r[2], desc_r[3]} + {46'h0, dcnt_r, 2'b00};
      end
      DS_STAT_WR: begin
        link.mem_addr  = tbl_base + TBL_STATUS_OFS;
        link.mem_wdata = {16'h0, done_cnt};
        if (desc_r[0][ENDPOINT_LAST_FLAG_REQ_BIT] &&
            (didx_r == '0 || didx_r == hdr_r[3][LEN_W-1:0])) begin
          link.mem_wdata[ENDPOINT_LAST_FLAG_BIT] = 1'b1;
        end
      end
      default: link.mem_addr = 64'h0;
    endcase
  end

  assign link.msi_valid = (st_r == DS_MSI);
  assign link.cfg_ack   = cfg_ack_r;
  assign link.cfg_rdata = cfg_rdata_r;
  assign busy           = (st_r != DS_IDLE);

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        hdr_r[i]  <= HDR_RESET;
        desc_r[i] <= 32'h0;
      end
      cfg_ack_r   <= 1'b0;
      cfg_rdata_r <= 32'h0;
      st_r        <= DS_IDLE;
      didx_r      <= '0;
      wsel_r      <= 2'h0;
      dcnt_r      <= '0;
    end else begin
      hdr_r       <= hdr_nxt;
      desc_r      <= desc_nxt;
      cfg_ack_r   <= cfg_ack_nxt;
      cfg_rdata_r <= cfg_rdata_nxt;
      st_r        <= st_nxt;
      didx_r      <= didx_nxt;
      wsel_r      <= wsel_nxt;
      dcnt_r      <= dcnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Endpoint memory.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ep_we) begin
      ep_mem[ep_waddr] <= link.rsp_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ep_rd_data <= 32'h0;
    end else begin
      ep_rd_data <= ep_mem[ep_rd_addr];
    end
  end

endmodule : cdr_dev

// *** tb/cdr_link_chk.sv ***
// Checker for the link between the read engine and its host end.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module cdr_link_chk
  import cdr_pkg::*;
(
  // Clock, reset and header access.
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cfg_valid,
  input wire logic        cfg_write,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic        cfg_ack,
  // Memory requests and message.
  input wire logic        mem_valid,
  input wire logic        mem_write,
  input wire logic        mem_ready,
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        rsp_valid,
  input wire logic        msi_valid,
  input wire logic        msi_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic        take;
  logic [63:0] base_r;
  logic [15:0] last_r;
  logic [15:0] cnt_r;
  logic        armed_r;
  assign take = cfg_valid && !cfg_ack && cfg_write;
  // Tracks the programmed table base, last index and completed count.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_r  <= '0;
      last_r  <= '0;
      cnt_r   <= '0;
      armed_r <= 1'b0;
    end else begin
      if (take && cfg_addr == HDR_UPPER_OFS) base_r[63:32] <= cfg_wdata;
      if (take && cfg_addr == HDR_LOWER_OFS) base_r[31:0] <= cfg_wdata;
      if (take && cfg_addr == HDR_LAST_OFS) begin
        last_r  <= cfg_wdata[15:0];
        cnt_r   <= '0;
        armed_r <= 1'b1;
      end else if (mem_valid && mem_ready && mem_write) cnt_r <= cnt_r + 16'h1;
      if (msi_valid && msi_ready) armed_r <= 1'b0;
    end
  end
  a_cfg_ack_next: assert property (cfg_valid && !cfg_ack |=> cfg_ack)
    else $error("header access not answered");
  a_cfg_ack_pulse: assert property (cfg_ack |=> !cfg_ack)
    else $error("header answer too long");
  a_read_answer: assert property (mem_valid && !mem_write |=> rsp_valid)
    else $error("read not answered");
  a_rsp_has_read: assert property (rsp_valid |-> $past(mem_valid) && !$past(mem_write))
    else $error("answer without read");
  a_read_spacing: assert property (mem_valid && !mem_write |=> !mem_valid)
    else $error("second read outstanding");
  a_no_early_start: assert property (mem_valid |-> armed_r)
    else $error("request before start");
  a_status_addr: assert property (mem_valid && mem_write |-> mem_addr == base_r + TBL_STATUS_OFS)
    else $error("write outside status dword");
  a_status_count: assert property (mem_valid && mem_write |-> mem_wdata[15:0] == cnt_r + 16'h1)
    else $error("wrong completed count");
  a_msi_after_last: assert property (msi_valid |-> cnt_r == last_r + 16'h1)
    else $error("message before last descriptor");
  a_flag_ends: assert property (mem_valid && mem_write && mem_wdata[ENDPOINT_LAST_FLAG_BIT] |->
    cnt_r == '0 || cnt_r == last_r)
    else $error("endpoint-last flag on a middle descriptor");
  c_status: cover property (mem_valid && mem_write && mem_wdata[ENDPOINT_LAST_FLAG_BIT]);
  c_msi: cover property (msi_valid);
  c_rsp: cover property (rsp_valid);
endmodule : cdr_link_chk

// *** tb/cdr_bench.sv ***
// Bench for the chained DMA read engine facing its host end.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/100ps
module cdr_bench
  import cdr_pkg::*;
;
  typedef struct packed {
    logic [11:0] ep;
    logic [15:0] hm;
    logic [31:0] d;
  } cdr_row_s;
  localparam cdr_row_s ROWS [5] = '{'{12'h003, 16'h0a00, 32'haaa0_0001},
    '{12'h004, 16'h0a04, 32'haaa0_0002}, '{12'h005, 16'h0a08, 32'haaa0_0003},
    '{12'h014, 16'h0c00, 32'hcccc_0001}, '{12'h015, 16'h0c04, 32'hcccc_0002}};
  localparam logic [31:0] DSC [12] = '{32'h0001_0003, 32'h3, 32'h0, 32'ha00,
    32'h0001_0000, 32'ha, 32'h0, 32'hb00, 32'h0001_0002, 32'h14, 32'h0, 32'hc00};
  logic              clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq, busy;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, ep_rd_data, rv;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, resp;
  logic [EP_AW-1:0]  ep_rd_addr;
  int                fail_count, n_compared;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  cdr_link_if cdr_link_if_inst ();
  cdr_dev cdr_dev_inst (.clk(clk), .nrst(nrst), .link(cdr_link_if_inst),
    .ep_rd_addr(ep_rd_addr), .ep_rd_data(ep_rd_data), .busy(busy));
  cdr_host cdr_host_inst (.clk(clk), .nrst(nrst), .link(cdr_link_if_inst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
  cdr_link_chk cdr_link_chk_inst (.clk(clk), .nrst(nrst),
    .cfg_valid(cdr_link_if_inst.cfg_valid), .cfg_write(cdr_link_if_inst.cfg_write),
    .cfg_addr(cdr_link_if_inst.cfg_addr), .cfg_wdata(cdr_link_if_inst.cfg_wdata),
    .cfg_ack(cdr_link_if_inst.cfg_ack), .mem_valid(cdr_link_if_inst.mem_valid),
    .mem_write(cdr_link_if_inst.mem_write), .mem_ready(cdr_link_if_inst.mem_ready),
    .mem_addr(cdr_link_if_inst.mem_addr), .mem_wdata(cdr_link_if_inst.mem_wdata),
    .rsp_valid(cdr_link_if_inst.rsp_valid), .msi_valid(cdr_link_if_inst.msi_valid),
    .msi_ready(cdr_link_if_inst.msi_ready));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic axw(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [15:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic wait_irq;
    while (irq !== 1'b1) begin
      @(posedge clk);
    end
  endtask : wait_irq
  task automatic summarize;
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ep_rd_addr} = '0;
    wstrb = 4'hf;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    axr(16'h2000);
    chk("unmapped read", {30'h0, RESP_DECERR}, {rv[29:0], resp});
    axw(16'h2000, 32'h1234_5678);
    chk("unmapped write", {30'h0, RESP_DECERR}, {30'h0, resp});
    for (int k = 0; k < 5; k++) axw(HC_MEM_BASE + ROWS[k].hm, ROWS[k].d);
    for (int k = 0; k < 12; k++) axw(16'h4910 + 16'(4 * k), DSC[k]);
    axw(HC_IRQ_MASK, 32'h1);
    axw(HC_HDR_BASE + {8'h00, HDR_CTRL_OFS}, 32'h3);
    axw(HC_HDR_BASE + {8'h00, HDR_UPPER_OFS}, 32'h0);
    axw(HC_HDR_BASE + {8'h00, HDR_LOWER_OFS}, 32'h900);
    axr(HC_HDR_BASE + {8'h00, HDR_LOWER_OFS});
    chk("table lower", 32'h900, rv);
    chk("busy idle", 32'h0, {31'h0, busy});
    axw(HC_HDR_BASE + {8'h00, HDR_LAST_OFS}, 32'h2);
    chk("busy run", 32'h1, {31'h0, busy});
    wait_irq();
    chk("irq done", 32'h1, {31'h0, irq});
    axr(HC_IRQ_STATUS);
    chk("irq status", 32'h1, rv);
    axr(16'h490c);
    chk("status dword", 32'h0001_0003, rv);
    axr(HC_MSI_COUNT);
    chk("message count", 32'h1, rv);
    for (int k = 0; k < 5; k++) begin
      ep_rd_addr <= ROWS[k].ep;
      repeat (2) @(posedge clk);
      chk("endpoint word", ROWS[k].d, ep_rd_data);
      axr(HC_MEM_BASE + ROWS[k].hm);
      chk("host word", ROWS[k].d, rv);
    end
    axw(HC_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(HC_IRQ_MASK, 32'h1);
    axw(HC_IRQ_STATUS, 32'h1);
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    axw(HC_HDR_BASE + {8'h00, HDR_LOWER_OFS}, 32'h910);
    axw(HC_HDR_BASE + {8'h00, HDR_LAST_OFS}, 32'h0);
    wait_irq();
    axr(16'h491c);
    chk("single status", 32'h0001_0001, rv);
    axr(HC_MSI_COUNT);
    chk("second message", 32'h2, rv);
    // Reset in mid-chain must stop the engine and clear busy, irq, the lower header dword and the message count.
    axw(HC_HDR_BASE + {8'h00, HDR_LAST_OFS}, 32'h0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("busy reset", 32'h0, {31'h0, busy});
    chk("irq reset", 32'h0, {31'h0, irq});
    nrst <= 1'b1;
    axr(HC_HDR_BASE + {8'h00, HDR_LOWER_OFS});
    chk("lower reset", HDR_RESET, rv);
    axr(HC_MSI_COUNT);
    chk("count reset", 32'h0, rv);
    summarize();
  end
endmodule : cdr_bench
